// File: design/reset_watchdog_sleep_control.sv
// reset delay timer, watchdog, sleep control and reset-cause flags with axi4-lite registers
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module reset_watchdog_sleep_control #(
   parameter int unsigned DRT_POR_CYCLES  = rst_wdt_pkg::DRT_POR_CYCLES,
   parameter int unsigned DRT_XTAL_CYCLES = rst_wdt_pkg::DRT_XTAL_CYCLES,
   parameter int unsigned WDT_BASE_CYCLES = rst_wdt_pkg::WDT_BASE_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // axi4-lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // configuration fuses and oscillator setting
   input  wire logic        watchdog_enable_fuse,
   input  wire logic        master_clear_fuse,
   input  wire logic [1:0]  osc_mode,
   // pins: master clear doubles as port_pin_three
   input  wire logic        master_clear_pin,
   input  wire logic        port_pin_zero,
   input  wire logic        port_pin_one,
   // to the core
   output logic             core_reset,
   output logic             osc_driver_en,
   output logic             io_hold
);

   typedef struct packed {
      rst_wdt_pkg::seq_state_t st;
      logic                    por_pending;
      logic [22:0]             drt_cnt;
      logic [22:0]             wdt_cnt;
      logic [7:0]              presc;
      logic [7:0]              option;
      logic                    to_n;
      logic                    pd_n;
      logic                    wake_flag;
      logic [2:0]              pin_snap;
      logic                    core_rst;
      logic                    osc_en;
      logic                    hold;
      logic [7:0]              aw_addr;
      logic                    aw_have;
      logic                    w_have;
      logic [31:0]             w_data;
      logic                    w_lane0;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [1:0]              rresp;
      logic [31:0]             rdata;
   } state_t;

   state_t q;
   state_t n;

   logic       master_clear_pin_eff;
   logic [2:0] watched;
   logic       wdt_tick;
   logic       wdt_timeout;
   logic       wake_en;

   // delay length minus one, so the counter ends at zero
   function automatic logic [22:0] drt_last(input logic [1:0] mode, input logic por);
      logic [22:0] len;
      if (mode == rst_wdt_pkg::low_power_crystal_mode || mode == rst_wdt_pkg::crystal_mode) begin
         len = 23'(DRT_XTAL_CYCLES);
      end else if (por) begin
         len = 23'(DRT_POR_CYCLES);
      end else begin
         len = 23'(rst_wdt_pkg::DRT_WARM_CYCLES);
      end
      return len - 23'h000001;
   endfunction : drt_last

   // last prescaler count for ratio 1:2^ps
   function automatic logic [7:0] presc_last(input logic [2:0] ps);
      logic [8:0] r;
      r = (9'h001 << ps) - 9'h001;
      return r[7:0];
   endfunction : presc_last

   // programmed fuse ties master clear high and frees the pin as an input
   assign master_clear_pin_eff = master_clear_fuse ? master_clear_pin : 1'b1;
   assign watched  = {master_clear_pin, port_pin_one, port_pin_zero};
   assign wake_en  = ~q.option[rst_wdt_pkg::OPT_WAKE_DIS_BIT];
   // watchdog counts in run and sleep; the clk-based count stands in for its own oscillator
   assign wdt_tick = (q.st == rst_wdt_pkg::ST_RUN || q.st == rst_wdt_pkg::ST_SLEEP)
                     && q.wdt_cnt == 23'(WDT_BASE_CYCLES - 1);
   assign wdt_timeout = watchdog_enable_fuse && wdt_tick
                        && (!q.option[rst_wdt_pkg::OPT_PSA_BIT]
                            || q.presc == presc_last(q.option[2:0]));

   // next state of the whole block
   always_comb begin
      logic wr_fire;
      logic do_clr;
      logic do_sleep;
      logic do_portrd;
      logic clr_wdt;
      wr_fire   = 1'b0;
      do_clr    = 1'b0;
      do_sleep  = 1'b0;
      do_portrd = 1'b0;
      clr_wdt   = 1'b0;
      n = q;

      // address and data are taken in either order and held until both are in
      if (s_axi_awvalid && q.awready) begin
         n.aw_have = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         n.w_have  = 1'b1;
         n.w_data  = s_axi_wdata;
         n.w_lane0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         wr_fire   = 1'b1;
         n.aw_have = 1'b0;
         n.w_have  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = rst_wdt_pkg::RESP_SLVERR;
      end
      if (wr_fire && q.aw_addr == rst_wdt_pkg::OPTION_OFFSET) begin
         n.bresp = rst_wdt_pkg::RESP_OKAY;
         if (q.w_lane0) begin
            n.option = q.w_data[7:0];
         end
      end
      if (wr_fire && q.aw_addr == rst_wdt_pkg::CMD_OFFSET) begin
         n.bresp = rst_wdt_pkg::RESP_OKAY;
         // instructions only execute while the core runs
         if (q.w_lane0 && q.st == rst_wdt_pkg::ST_RUN) begin
            do_clr    = q.w_data[rst_wdt_pkg::CMD_WATCHDOG_CLEAR_INSTR_BIT];
            do_sleep  = q.w_data[rst_wdt_pkg::CMD_SLEEP_BIT];
            do_portrd = q.w_data[rst_wdt_pkg::CMD_PORTRD_BIT];
         end
      end
      if (wr_fire && q.aw_addr == rst_wdt_pkg::STATUS_OFFSET) begin
         n.bresp = rst_wdt_pkg::RESP_OKAY;                                    // read-only, write ignored
      end

      // read channel: one cycle to the answer
      if (q.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         n.rvalid = 1'b1;
         n.rresp  = rst_wdt_pkg::RESP_OKAY;
         n.rdata  = 32'h00000000;
         if (s_axi_araddr == rst_wdt_pkg::STATUS_OFFSET) begin
            n.rdata[rst_wdt_pkg::ST_WAKE_BIT]     = q.wake_flag;
            n.rdata[rst_wdt_pkg::ST_TO_BIT]       = q.to_n;
            n.rdata[rst_wdt_pkg::ST_PD_BIT]       = q.pd_n;
            n.rdata[rst_wdt_pkg::ST_CORE_RST_BIT] = q.core_rst;
            n.rdata[rst_wdt_pkg::ST_ASLEEP_BIT]   = (q.st == rst_wdt_pkg::ST_SLEEP);
         end else if (s_axi_araddr != rst_wdt_pkg::OPTION_OFFSET && s_axi_araddr != rst_wdt_pkg::CMD_OFFSET) begin
            n.rresp = rst_wdt_pkg::RESP_SLVERR;
         end
      end

      // snapshot of watched pins at each port operation
      if (do_portrd) begin
         n.pin_snap = watched;
      end

      // reset sequencer; all sources funnel into one registered core reset
      case (q.st)
         rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN: begin
            if (master_clear_pin_eff) begin
               n.st      = rst_wdt_pkg::ST_DELAY;
               n.drt_cnt = drt_last(osc_mode, q.por_pending);
            end
         end
         rst_wdt_pkg::ST_DELAY: begin
            if (!master_clear_pin_eff) begin
               n.st = rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN;
            end else if (q.drt_cnt == 23'h000000) begin
               n.st          = rst_wdt_pkg::ST_RUN;
               n.por_pending = 1'b0;
               n.osc_en      = 1'b1;
            end else begin
               n.drt_cnt = q.drt_cnt - 23'h000001;
            end
         end
         rst_wdt_pkg::ST_RUN: begin
            if (!master_clear_pin_eff) begin
               n.st        = rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN;
               n.wake_flag = 1'b0;
            end else if (wdt_timeout) begin
               // internal reset only: no path drives the master clear pin
               n.st        = rst_wdt_pkg::ST_DELAY;
               n.drt_cnt   = drt_last(osc_mode, 1'b0);
               n.to_n      = 1'b0;
               n.wake_flag = 1'b0;
            end else if (do_sleep) begin
               n.st     = rst_wdt_pkg::ST_SLEEP;
               n.to_n   = 1'b1;
               n.pd_n   = 1'b0;
               n.osc_en = 1'b0;
               n.hold   = 1'b1;
               clr_wdt  = 1'b1;
            end
         end
         rst_wdt_pkg::ST_SLEEP: begin
            // any wake is a device reset and clears the watchdog
            if (!master_clear_pin_eff) begin
               n.st        = rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN;
               n.to_n      = 1'b1;
               n.pd_n      = 1'b0;
               n.wake_flag = 1'b0;
            end else if (wdt_timeout) begin
               n.st        = rst_wdt_pkg::ST_DELAY;
               n.drt_cnt   = drt_last(osc_mode, 1'b0);
               n.to_n      = 1'b0;
               n.pd_n      = 1'b0;
               n.wake_flag = 1'b0;
            end else if (wake_en && watched != q.pin_snap) begin
               // a stale snapshot makes this fire on the first sleep cycle
               n.st        = rst_wdt_pkg::ST_DELAY;
               n.drt_cnt   = drt_last(osc_mode, 1'b0);
               n.to_n      = 1'b1;
               n.pd_n      = 1'b0;
               n.wake_flag = 1'b1;
            end
            if (n.st != rst_wdt_pkg::ST_SLEEP) begin
               n.hold  = 1'b0;
               clr_wdt = 1'b1;
            end
         end
         default: begin
            n.st = rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN;
         end
      endcase

      // watchdog base counter and prescaler
      if (q.st != rst_wdt_pkg::ST_RUN && q.st != rst_wdt_pkg::ST_SLEEP) begin
         n.wdt_cnt = 23'h000000;
         n.presc   = 8'h00;
      end else if (clr_wdt || do_clr || wdt_timeout) begin
         n.wdt_cnt = 23'h000000;
         n.presc   = 8'h00;
      end else if (wdt_tick) begin
         n.wdt_cnt = 23'h000000;
         if (q.option[rst_wdt_pkg::OPT_PSA_BIT]) begin
            n.presc = q.presc + 8'h01;
         end
      end else begin
         n.wdt_cnt = q.wdt_cnt + 23'h000001;
      end

      n.core_rst = (n.st == rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN || n.st == rst_wdt_pkg::ST_DELAY);
      n.awready  = !n.aw_have && !n.bvalid;
      n.wready   = !n.w_have && !n.bvalid;
      n.arready  = !n.rvalid;
   end

   // one register for all state; power-up loads the flags as 0,1,1
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q             <= '0;
         q.st          <= rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN;
         q.por_pending <= 1'b1;
         q.option      <= rst_wdt_pkg::OPTION_RESET;
         q.to_n        <= rst_wdt_pkg::TO_N_RESET;
         q.pd_n        <= rst_wdt_pkg::PD_N_RESET;
         q.wake_flag   <= rst_wdt_pkg::WAKE_RESET;
         q.core_rst    <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign core_reset    = q.core_rst;
   assign osc_driver_en = q.osc_en;
   assign io_hold       = q.hold;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence sleep_entry_s;
      q.st == rst_wdt_pkg::ST_RUN ##1 q.st == rst_wdt_pkg::ST_SLEEP;
   endsequence

   sequence sleep_exit_s;
      q.st == rst_wdt_pkg::ST_SLEEP ##1 q.st != rst_wdt_pkg::ST_SLEEP;
   endsequence

   AST_RELEASE_AT_EXPIRY: assert property ($fell(q.core_rst) |-> $past(q.st) == rst_wdt_pkg::ST_DELAY
      && $past(q.drt_cnt) == 23'h000000)
      else $error("core reset released before delay expired");
   AST_DELAY_LOAD: assert property ($past(q.st) == rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN && q.st == rst_wdt_pkg::ST_DELAY
      |-> q.drt_cnt == drt_last($past(osc_mode), $past(q.por_pending)))
      else $error("delay loaded with wrong length");
   AST_WAIT_MASTER_CLEAR_PIN_LOW: assert property (q.st == rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN && !master_clear_pin_eff
      |=> q.st == rst_wdt_pkg::ST_WAIT_MASTER_CLEAR_PIN && q.core_rst)
      else $error("delay started with master clear low");
   AST_FUSE_OFF: assert property (!watchdog_enable_fuse |-> !wdt_timeout)
      else $error("watchdog timed out while fused off");
   AST_SLEEP_ENTRY: assert property (sleep_entry_s |-> q.to_n && !q.pd_n && !q.osc_en && q.hold
      && q.wdt_cnt == 23'h000000)
      else $error("sleep entry effects missing");
   AST_WDT_WAKE: assert property (q.st == rst_wdt_pkg::ST_SLEEP && wdt_timeout && master_clear_pin_eff
      |=> q.st == rst_wdt_pkg::ST_DELAY && !q.to_n && !q.pd_n && !q.wake_flag ##1 q.core_rst)
      else $error("watchdog wake did not start delay");
   AST_PIN_WAKE: assert property (q.st == rst_wdt_pkg::ST_SLEEP && !wdt_timeout && master_clear_pin_eff && wake_en
      && watched != q.pin_snap |=> q.wake_flag && q.to_n && q.st == rst_wdt_pkg::ST_DELAY)
      else $error("pin change wake missed");
   AST_WAKE_CLEARS_WDT: assert property (sleep_exit_s |-> q.wdt_cnt == 23'h000000 && !q.hold)
      else $error("watchdog not cleared on wake");
   AST_WATCHDOG_CLEAR_INSTR: assert property ($rose(q.bvalid) && $past(q.aw_addr) == rst_wdt_pkg::CMD_OFFSET
      && $past(q.w_lane0) && $past(q.w_data[0]) && $past(q.st) == rst_wdt_pkg::ST_RUN && q.st == rst_wdt_pkg::ST_RUN
      |-> q.wdt_cnt == 23'h000000 && q.presc == 8'h00)
      else $error("watchdog clear ignored");
   AST_FLAGS_HOLD: assert property (q.st == rst_wdt_pkg::ST_RUN ##1 q.st == rst_wdt_pkg::ST_RUN
      |-> $stable({q.to_n, q.pd_n, q.wake_flag}))
      else $error("reset flags changed without reset");

endmodule : reset_watchdog_sleep_control

`default_nettype wire

// File: pkg/rst_wdt_pkg.sv
// shared constants and types for the reset, watchdog and sleep controller
package rst_wdt_pkg;

   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OPTION_OFFSET = 8'h00;   // timer_prescale_option, write only
   localparam logic [7:0] CMD_OFFSET    = 8'h04;   // core instruction strobes, write only
   localparam logic [7:0] STATUS_OFFSET = 8'h08;   // reset cause and block state, read only

   // timer_prescale_option fields
   localparam int OPT_WAKE_DIS_BIT = 7;            // wake-on-change disabled when set
   localparam int OPT_PSA_BIT      = 3;            // prescaler_assign_bit: 1 = watchdog
   localparam int OPT_PS_LSB       = 0;            // prescaler_ratio_field, 3 bits
   localparam logic [7:0] OPTION_RESET = 8'hff;

   // command register strobes
   localparam int CMD_WATCHDOG_CLEAR_INSTR_BIT   = 0;            // watchdog_clear_instr
   localparam int CMD_SLEEP_BIT    = 1;            // sleep instruction
   localparam int CMD_PORTRD_BIT   = 2;            // file or bit operation on the port

   // status register fields
   localparam int ST_WAKE_BIT      = 7;            // pin_change_wake_flag
   localparam int ST_TO_BIT        = 4;            // timeout_flag_n
   localparam int ST_PD_BIT        = 3;            // powerdown_flag_n
   localparam int ST_CORE_RST_BIT  = 1;
   localparam int ST_ASLEEP_BIT    = 0;

   // flag values after power-up
   localparam logic TO_N_RESET  = 1'b1;
   localparam logic PD_N_RESET  = 1'b1;
   localparam logic WAKE_RESET  = 1'b0;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // timing: clock rate and printed times
   localparam int unsigned CLK_FREQ_KHZ       = 250000;
   localparam int unsigned DRT_POR_TIME_MS    = 1;
   localparam int unsigned DRT_WARM_TIME_US   = 10;
   localparam int unsigned DRT_XTAL_TIME_MS   = 18;
   localparam int unsigned WDT_BASE_TIME_MS   = 18;
   localparam int unsigned DRT_POR_CYCLES     = DRT_POR_TIME_MS * CLK_FREQ_KHZ;
   localparam int unsigned DRT_WARM_CYCLES    = DRT_WARM_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int unsigned DRT_XTAL_CYCLES    = DRT_XTAL_TIME_MS * CLK_FREQ_KHZ;
   localparam int unsigned WDT_BASE_CYCLES    = WDT_BASE_TIME_MS * CLK_FREQ_KHZ;

   localparam int CNT_W = 23;                      // holds 18 ms of cycles

   // oscillator configuration
   typedef enum logic [1:0] {
      internal_osc_mode,
      external_rc_mode,
      low_power_crystal_mode,
      crystal_mode
   } osc_mode_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_WAIT_MASTER_CLEAR_PIN,
      ST_DELAY,
      ST_RUN,
      ST_SLEEP
   } seq_state_t;

endpackage : rst_wdt_pkg

// File: verif/pin_partner.sv
// board-side partner: master clear pin and watched port pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // clock
   input  wire logic       clk,
   // requests from the bench
   input  wire logic       master_clear_pin_rel,
   input  wire logic [1:0] pin_set,
   // pins toward the device
   output var logic        master_clear_pin,
   output var logic        port_pin_zero,
   output var logic        port_pin_one
);
   // master clear starts low so the device waits in reset at power-up
   initial begin
      master_clear_pin = 1'b0;
      port_pin_zero = 1'b0;
      port_pin_one = 1'b0;
   end
   // pins move one edge after a request, like a slow board driver
   always @(posedge clk) begin
      master_clear_pin <= master_clear_pin_rel;
      {port_pin_one, port_pin_zero} <= pin_set;
   end
endmodule : pin_partner
`default_nettype wire

// File: verif/tb_reset_watchdog_sleep_control.sv
// self-checking bench for the reset, watchdog and sleep controller
`timescale 1ns/1ps
`default_nettype none
module tb_reset_watchdog_sleep_control;
   logic        clk = 1'b0, sys_rst = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, pin_set = 2'h0;
   logic [31:0] s_axi_rdata, rd;
   logic        watchdog_enable_fuse = 1'b1, master_clear_fuse = 1'b1, master_clear_pin_rel = 1'b0;
   logic [1:0]  osc_mode = 2'h0;
   logic        master_clear_pin, port_pin_zero, port_pin_one, core_reset, osc_driver_en, io_hold;
   int          fail_count = 0, tests_run = 0, n;

   // shortened counts keep the run brief; the warm delay stays at its full value
   reset_watchdog_sleep_control #(.DRT_POR_CYCLES(40), .DRT_XTAL_CYCLES(60), .WDT_BASE_CYCLES(50))
   i_reset_watchdog_sleep_control (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .watchdog_enable_fuse, .master_clear_fuse, .osc_mode,
      .master_clear_pin, .port_pin_zero, .port_pin_one, .core_reset, .osc_driver_en, .io_hold);

   pin_partner i_pin_partner (.clk, .master_clear_pin_rel, .pin_set, .master_clear_pin, .port_pin_zero,
      .port_pin_one);

   // 250 mhz clock
   always #2 clk = ~clk;

   task automatic summarize;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // a range check on a measured cycle count
   task automatic chk_rng(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask : chk_rng

   // status word built from the flag positions
   function automatic logic [31:0] stat(input logic w, t, p, c, s);
      stat = 32'h0;
      stat[rst_wdt_pkg::ST_WAKE_BIT] = w;
      stat[rst_wdt_pkg::ST_TO_BIT] = t;
      stat[rst_wdt_pkg::ST_PD_BIT] = p;
      stat[rst_wdt_pkg::ST_CORE_RST_BIT] = c;
      stat[rst_wdt_pkg::ST_ASLEEP_BIT] = s;
   endfunction : stat

   // address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // let one edge pass so a following call never re-raises bready in this time step
      @(posedge clk);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask : rdr

   // counts edges until core reset shows the wanted level
   task automatic wait_core(input logic v);
      n = 0;
      while (core_reset !== v) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_core

   // hang guard, well beyond the roughly 13000 cycles the tests take
   initial begin
      #200000;
      fail_count++;
      summarize();
   end

   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (100) @(posedge clk);
      chk(core_reset, 1'b1);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(0, 1, 1, 1, 0));
      master_clear_pin_rel <= 1'b1;
      wait_core(1'b0);
      chk_rng(n, 40, 46);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(0, 1, 1, 0, 0));
      rdr(8'h0c);
      chk(rsp, rst_wdt_pkg::RESP_SLVERR);
      // watchdog without prescaler, wake-on-change on
      wr(rst_wdt_pkg::OPTION_OFFSET, 32'h0);
      for (int i = 0; i < 4; i++) begin
         repeat (20) @(posedge clk);
         wr(rst_wdt_pkg::CMD_OFFSET, 32'h1);
      end
      chk(core_reset, 1'b0);
      wait_core(1'b1);
      chk_rng(n, 30, 55);
      wait_core(1'b0);
      chk_rng(n, 2500, 2506);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(0, 0, 1, 0, 0));
      // snapshot, sleep, then a pin change wakes
      wr(rst_wdt_pkg::CMD_OFFSET, 32'h4);
      wr(rst_wdt_pkg::CMD_OFFSET, 32'h2);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(0, 1, 0, 0, 1));
      chk({io_hold, osc_driver_en}, 2'b10);
      pin_set <= 2'h1;
      wait_core(1'b1);
      chk_rng(n, 1, 4);
      wait_core(1'b0);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(1, 1, 0, 0, 0));
      // sleep with fresh snapshot: watchdog wakes after a full period
      wr(rst_wdt_pkg::CMD_OFFSET, 32'h4);
      wr(rst_wdt_pkg::CMD_OFFSET, 32'h2);
      wait_core(1'b1);
      chk_rng(n, 45, 55);
      wait_core(1'b0);
      chk_rng(n, 2500, 2506);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(0, 0, 0, 0, 0));
      // pins moved since the last snapshot: sleep ends at once
      pin_set <= 2'h0;
      repeat (2) @(posedge clk);
      wr(rst_wdt_pkg::CMD_OFFSET, 32'h2);
      wait_core(1'b1);
      chk_rng(n, 0, 4);
      wait_core(1'b0);
      // master clear pulse while running leaves timeout and powerdown alone
      master_clear_pin_rel <= 1'b0;
      repeat (4) @(posedge clk);
      master_clear_pin_rel <= 1'b1;
      wait_core(1'b0);
      rdr(rst_wdt_pkg::STATUS_OFFSET);
      chk(rd, stat(0, 1, 0, 0, 0));
      // fuses: watchdog off, master clear tied high
      watchdog_enable_fuse <= 1'b0;
      master_clear_fuse <= 1'b0;
      master_clear_pin_rel <= 1'b0;
      repeat (300) @(posedge clk);
      chk({core_reset, osc_driver_en}, 2'b01);
      summarize();
   end
endmodule : tb_reset_watchdog_sleep_control
`default_nettype wire
